/* File: inc/ata_role_pkg.sv */
/*
  Constants and types for the parallel-port line-role multiplexer.
  Assumes a 16-bit data bus and the host pins gathered into one vector.
*/
package ata_role_pkg;

  // ----------------------------------------------------------------
  // Bus width
  // ----------------------------------------------------------------
  localparam int DW = 16;

  // ----------------------------------------------------------------
  // Host pin vector layout (link domain synchroniser)
  // ----------------------------------------------------------------
  localparam int PIN_RST   = 0;
  localparam int PIN_DD    = 1;
  localparam int PIN_DIOR  = 17;
  localparam int PIN_DIOW  = 18;
  localparam int PIN_DMACK = 19;
  localparam int PIN_PDIAG = 20;
  localparam int PIN_DASP  = 21;
  localparam int PIN_W     = 22;

  // ----------------------------------------------------------------
  // Core level vector layout (system to link crossing)
  // ----------------------------------------------------------------
  localparam int LV_UDMA  = 0;
  localparam int LV_READ  = 1;
  localparam int LV_DREQ  = 2;
  localparam int LV_IREQ  = 3;
  localparam int LV_IEN   = 4;
  localparam int LV_PDIAG = 5;
  localparam int LV_DASP  = 6;
  localparam int LV_WAIT  = 7;
  localparam int LV_CE    = 8;
  localparam int LV_W     = 9;

  // ----------------------------------------------------------------
  // Status vector layout (link to system crossing)
  // ----------------------------------------------------------------
  localparam int ST_ACT   = 0;
  localparam int ST_STOP  = 1;
  localparam int ST_PDIAG = 2;
  localparam int ST_DASP  = 3;
  localparam int ST_W     = 4;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  localparam logic OD_PULL   = 1'b0;
  localparam logic STB_INIT  = 1'b0;
  localparam logic WAIT_LVL  = 1'b0;

  // ----------------------------------------------------------------
  // Line roles
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ROLE_PIO, ROLE_OUT, ROLE_IN} role_t;

endpackage

/* File: inc/stream_if.sv */
/*
  Valid/ready word carrier between the port logic and its buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface stream_if #(parameter int W = 16) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: logic/word_buf.sv */
/*
  Small word buffer with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ns
module word_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Streams
  stream_if.snk    wr,
  stream_if.src    rd
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } buf_t;

  buf_t st_ff, nxt_st;

  if (DEPTH < 2) begin
    $error("word_buf needs at least two entries");
  end

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign wr.ready = (st_ff.cnt != CW'(DEPTH));
  assign rd.valid = (st_ff.cnt != '0);
  assign rd.data  = st_ff.mem[st_ff.rp];

  always_comb begin
    nxt_st = st_ff;
    if (rst) begin
      nxt_st = '0;
    end else if (ce) begin
      if (wr.valid && wr.ready) begin
        nxt_st.mem[st_ff.wp] = wr.data;
        nxt_st.wp            = step(st_ff.wp);
      end
      if (rd.valid && rd.ready) begin
        nxt_st.rp = step(st_ff.rp);
      end
      nxt_st.cnt = st_ff.cnt + CW'(wr.valid && wr.ready)
                 - CW'(rd.valid && rd.ready);
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

endmodule

/* File: logic/ata_udma_role_mux.sv */
/*
  Device-side line-role multiplexer of the parallel host port.
  Host pins are handled on link_clk; the transfer engine sits on clk.
  Assumes pins are asynchronous to both clocks and that the pad ring
  resolves each output enable into the wire level.
*/
// Operation
// - Only DIOW-, DIOR-, IORDY change meaning; other lines stay fixed.
// - Burst roles apply only once an Ultra DMA mode was selected.
// - DMACK- assertion switches the three lines into burst roles.
// - DMACK- release returns the three lines to programmed-I/O roles.
// - Out: IORDY=DDMARDY-, DIOR-=HSTROBE; in: DIOR-=HDMARDY-, IORDY=DSTROBE.
// - DMARQ, IORDY, INTRQ are tri-state outputs; inputs never driven.
// - PDIAG- and DASP- are open drain: pull low or release, and sample.
// - Data-out words are taken on both edges of HSTROBE.
// - Receiver pauses by negating its ready line; sender holds off.
`timescale 1ns/1ns
module ata_udma_role_mux
  import ata_role_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // System clock domain
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          rst,
  // Link clock domain
  input  wire logic          link_clk,
  // Host pins, inputs
  input  wire logic          reset_n_i,
  input  wire logic          dmack_n_i,
  input  wire logic          dior_n_i,
  input  wire logic          diow_n_i,
  input  wire logic [DW-1:0] dd_i,
  input  wire logic          pdiag_n_i,
  input  wire logic          dasp_n_i,
  // Host pins, outputs and enables
  output logic      [DW-1:0] dd_o,
  output logic               dd_oe,
  output logic               iordy_o,
  output logic               iordy_oe,
  output logic               dmarq_o,
  output logic               dmarq_oe,
  output logic               intrq_o,
  output logic               intrq_oe,
  output logic               pdiag_n_o,
  output logic               pdiag_n_oe,
  output logic               dasp_n_o,
  output logic               dasp_n_oe,
  // Transfer engine controls
  input  wire logic          udma_mode,
  input  wire logic          xfer_read,
  input  wire logic          dma_req,
  input  wire logic          intr_req,
  input  wire logic          intr_en,
  input  wire logic          pdiag_assert,
  input  wire logic          dasp_assert,
  input  wire logic          pio_wait,
  // Received words
  output logic      [DW-1:0] rx_data,
  output logic               rx_valid,
  input  wire logic          rx_ready,
  // Words to send
  input  wire logic [DW-1:0] tx_data,
  input  wire logic          tx_valid,
  output logic               tx_ready,
  // Port status
  output logic               burst_active,
  output logic               stop_seen,
  output logic               pdiag_low,
  output logic               dasp_low
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [LV_W-1:0]  lv_s1;
    logic [LV_W-1:0]  lv_s2;
    logic             rst_s1;
    logic             rst_s2;
    logic             txr_s1;
    logic             txr_s2;
    logic             rxa_s1;
    logic             rxa_s2;
    role_t            role;
    logic             hs_prev;
    logic             stop;
    logic             tx_ack;
    logic             rx_req;
    logic [DW-1:0]    rx_word;
    logic [ST_W-1:0]  st;
    logic [DW-1:0]    dd_o;
    logic             dd_oe;
    logic             iordy_o;
    logic             iordy_oe;
    logic             dmarq_o;
    logic             dmarq_oe;
    logic             intrq_o;
    logic             intrq_oe;
    logic             od_o;
    logic             pdiag_oe;
    logic             dasp_oe;
  } link_t;

  typedef struct packed {
    logic             rxr_s1;
    logic             rxr_s2;
    logic             txa_s1;
    logic             txa_s2;
    logic [ST_W-1:0]  st_s1;
    logic [ST_W-1:0]  st_s2;
    logic             rx_seen;
    logic             rx_valid;
    logic [DW-1:0]    rx_data;
    logic             tx_req;
    logic [DW-1:0]    tx_word;
    logic             tx_ready;
  } sys_t;

  link_t l_ff, nxt_l;
  sys_t  s_ff, nxt_s;

  if (BUF_DEPTH < 2) begin
    $error("BUF_DEPTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // Receive buffer on the link clock
  // ----------------------------------------------------------------
  stream_if #(.W(DW)) rxin ();
  stream_if #(.W(DW)) rxout ();

  word_buf #(.W(DW), .DEPTH(BUF_DEPTH)) u_buf (
    .clk (link_clk),
    .rst (l_ff.rst_s2 || !l_ff.pin_s2[PIN_RST]),
    .ce  (l_ff.lv_s2[LV_CE]),
    .wr  (rxin),
    .rd  (rxout)
  );

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic          dmack_l;
  logic          hstb;
  logic          stop_l;
  logic          tx_pend;

  always_comb begin
    dmack_l      = !l_ff.pin_s2[PIN_DMACK];
    hstb         = l_ff.pin_s2[PIN_DIOR];
    stop_l       = l_ff.pin_s2[PIN_DIOW];
    tx_pend      = (l_ff.txr_s2 != l_ff.tx_ack);
    nxt_l        = l_ff;
    rxin.valid   = 1'b0;
    rxin.data    = l_ff.pin_s2[PIN_DD +: DW];
    rxout.ready  = 1'b0;
    if (l_ff.rst_s2 || !l_ff.pin_s2[PIN_RST]) begin
      nxt_l = '0;
    end else if (l_ff.lv_s2[LV_CE]) begin
      unique case (l_ff.role)
        ROLE_PIO: begin
          // Roles only move once a burst mode is chosen and granted
          if (dmack_l && l_ff.lv_s2[LV_UDMA]) begin
            nxt_l.role    = l_ff.lv_s2[LV_READ] ? ROLE_IN : ROLE_OUT;
            nxt_l.iordy_o = l_ff.lv_s2[LV_READ] ? STB_INIT
                                                : !rxin.ready;
          end else begin
            nxt_l.iordy_o = WAIT_LVL;
          end
        end
        ROLE_OUT: begin
          if (!dmack_l) begin
            nxt_l.role = ROLE_PIO;
          end else if (hstb != l_ff.hs_prev) begin
            rxin.valid = 1'b1;
          end
          // DDMARDY- negated while the buffer is full
          nxt_l.iordy_o = !rxin.ready;
        end
        ROLE_IN: begin
          if (!dmack_l) begin
            nxt_l.role = ROLE_PIO;
          end else if (tx_pend && !hstb && !stop_l) begin
            nxt_l.dd_o    = s_ff.tx_word;
            nxt_l.iordy_o = !l_ff.iordy_o;
            nxt_l.tx_ack  = !l_ff.tx_ack;
          end
        end
        default: nxt_l.role = ROLE_PIO;
      endcase
      nxt_l.hs_prev  = hstb;
      nxt_l.stop     = (l_ff.role != ROLE_PIO) && stop_l;
      nxt_l.dd_oe    = (nxt_l.role == ROLE_IN);
      nxt_l.iordy_oe = (nxt_l.role != ROLE_PIO)
                       || l_ff.lv_s2[LV_WAIT];
      nxt_l.dmarq_o  = l_ff.lv_s2[LV_DREQ];
      nxt_l.dmarq_oe = l_ff.lv_s2[LV_DREQ] || dmack_l;
      nxt_l.intrq_o  = l_ff.lv_s2[LV_IREQ];
      nxt_l.intrq_oe = l_ff.lv_s2[LV_IEN];
      nxt_l.od_o     = OD_PULL;
      nxt_l.pdiag_oe = l_ff.lv_s2[LV_PDIAG];
      nxt_l.dasp_oe  = l_ff.lv_s2[LV_DASP];
      // One word in flight toward the system side at a time
      if (rxout.valid && (l_ff.rx_req == l_ff.rxa_s2)) begin
        rxout.ready   = 1'b1;
        nxt_l.rx_word = rxout.data;
        nxt_l.rx_req  = !l_ff.rx_req;
      end
      nxt_l.st[ST_ACT]   = (l_ff.role != ROLE_PIO);
      nxt_l.st[ST_STOP]  = l_ff.stop;
      nxt_l.st[ST_PDIAG] = !l_ff.pin_s2[PIN_PDIAG];
      nxt_l.st[ST_DASP]  = !l_ff.pin_s2[PIN_DASP];
    end
    nxt_l.pin_s1 = {dasp_n_i, pdiag_n_i, dmack_n_i, diow_n_i,
                    dior_n_i, dd_i, reset_n_i};
    nxt_l.pin_s2 = l_ff.pin_s1;
    nxt_l.lv_s1  = {ce, pio_wait, dasp_assert, pdiag_assert, intr_en,
                    intr_req, dma_req, xfer_read, udma_mode};
    nxt_l.lv_s2  = l_ff.lv_s1;
    nxt_l.rst_s1 = rst;
    nxt_l.rst_s2 = l_ff.rst_s1;
    nxt_l.txr_s1 = s_ff.tx_req;
    nxt_l.txr_s2 = l_ff.txr_s1;
    nxt_l.rxa_s1 = s_ff.rx_seen;
    nxt_l.rxa_s2 = l_ff.rxa_s1;
  end

  always_ff @(posedge link_clk) begin
    l_ff <= nxt_l;
  end

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    if (rst) begin
      nxt_s = '0;
    end else if (ce) begin
      nxt_s.rxr_s1 = l_ff.rx_req;
      nxt_s.rxr_s2 = s_ff.rxr_s1;
      nxt_s.txa_s1 = l_ff.tx_ack;
      nxt_s.txa_s2 = s_ff.txa_s1;
      nxt_s.st_s1  = l_ff.st;
      nxt_s.st_s2  = s_ff.st_s1;
      if (s_ff.rx_valid && rx_ready) begin
        nxt_s.rx_valid = 1'b0;
      end
      // Word stays put in the link register until acknowledged
      if ((s_ff.rxr_s2 != s_ff.rx_seen) && !s_ff.rx_valid) begin
        nxt_s.rx_valid = 1'b1;
        nxt_s.rx_data  = l_ff.rx_word;
        nxt_s.rx_seen  = !s_ff.rx_seen;
      end
      if (tx_valid && s_ff.tx_ready) begin
        nxt_s.tx_word = tx_data;
        nxt_s.tx_req  = !s_ff.tx_req;
      end
      nxt_s.tx_ready = (nxt_s.tx_req == nxt_s.txa_s2);
    end
  end

  always_ff @(posedge clk) begin
    s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dd_o         = l_ff.dd_o;
  assign dd_oe        = l_ff.dd_oe;
  assign iordy_o      = l_ff.iordy_o;
  assign iordy_oe     = l_ff.iordy_oe;
  assign dmarq_o      = l_ff.dmarq_o;
  assign dmarq_oe     = l_ff.dmarq_oe;
  assign intrq_o      = l_ff.intrq_o;
  assign intrq_oe     = l_ff.intrq_oe;
  assign pdiag_n_o    = l_ff.od_o;
  assign pdiag_n_oe   = l_ff.pdiag_oe;
  assign dasp_n_o     = l_ff.od_o;
  assign dasp_n_oe    = l_ff.dasp_oe;
  assign rx_data      = s_ff.rx_data;
  assign rx_valid     = s_ff.rx_valid;
  assign tx_ready     = s_ff.tx_ready;
  assign burst_active = s_ff.st_s2[ST_ACT];
  assign stop_seen    = s_ff.st_s2[ST_STOP];
  assign pdiag_low    = s_ff.st_s2[ST_PDIAG];
  assign dasp_low     = s_ff.st_s2[ST_DASP];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic lrst;
  logic lce;
  assign lrst = l_ff.rst_s2 || !l_ff.pin_s2[PIN_RST];
  assign lce  = l_ff.lv_s2[LV_CE];

  a_role_enter: assert property (@(posedge link_clk) disable iff (lrst)
    (lce && l_ff.role == ROLE_PIO && dmack_l && l_ff.lv_s2[LV_UDMA])
    |=> (l_ff.role != ROLE_PIO))
    else $error("role did not switch on grant");
  a_mode_gate: assert property (@(posedge link_clk) disable iff (lrst)
    (l_ff.role == ROLE_PIO && !l_ff.lv_s2[LV_UDMA]) |=> l_ff.role == ROLE_PIO)
    else $error("burst role without mode");
  a_role_exit: assert property (@(posedge link_clk) disable iff (lrst)
    (lce && !dmack_l) |=> (l_ff.role == ROLE_PIO) && !l_ff.dd_oe)
    else $error("role kept after release");
  a_strobe_push: assert property (@(posedge link_clk) disable iff (lrst)
    (lce && l_ff.role == ROLE_OUT && dmack_l && hstb != l_ff.hs_prev)
    |-> rxin.valid && rxin.data == l_ff.pin_s2[PIN_DD +: DW] ##1 rxout.valid)
    else $error("strobe edge not captured");
  a_full_pause: assert property (@(posedge link_clk) disable iff (lrst)
    (lce && l_ff.role == ROLE_OUT && dmack_l && !rxin.ready) |=> l_ff.iordy_o)
    else $error("ready not negated when full");
  a_stop_holds: assert property (@(posedge link_clk) disable iff (lrst)
    (l_ff.role == ROLE_IN && (stop_l || hstb)) |=> $stable(l_ff.iordy_o))
    else $error("strobe moved while paused");
  a_word_send: assert property (@(posedge link_clk) disable iff (lrst)
    (lce && l_ff.role == ROLE_IN && dmack_l && tx_pend && !hstb && !stop_l)
    |=> (l_ff.iordy_o != $past(l_ff.iordy_o)) && l_ff.dd_oe)
    else $error("word not strobed out");
  a_od_pull: assert property (@(posedge link_clk) disable iff (lrst)
    (lce && l_ff.lv_s2[LV_PDIAG]) |=> (pdiag_n_oe && pdiag_n_o == OD_PULL))
    else $error("open drain line not pulled");
  a_dd_drive: assert property (@(posedge link_clk) disable iff (lrst)
    dd_oe |-> (l_ff.role == ROLE_IN))
    else $error("data bus driven outside read burst");
  a_rx_hold: assert property (@(posedge clk) disable iff (rst)
    (ce && rx_valid && !rx_ready) |=> (rx_valid && $stable(rx_data)))
    else $error("received word dropped");

  c_burst_out: cover property (@(posedge link_clk) rxin.valid && rxin.ready);
  c_burst_in: cover property (@(posedge link_clk)
    l_ff.role == ROLE_IN ##1 $changed(l_ff.iordy_o));
  c_pause: cover property (@(posedge link_clk)
    l_ff.role == ROLE_OUT && !rxin.ready);
  c_stop: cover property (@(posedge clk) stop_seen);

endmodule

/* File: testbench/host_model.sv */
/*
  Host side of the parallel cable, behavioural.
  Assumes the bench resolves the data bus and the IORDY wire.
*/
`timescale 1ns/1ns
module host_model
  import ata_role_pkg::*;
(
  // Clock
  input  wire logic          link_clk,
  // Host drives
  output logic               reset_n,
  output logic               dmack_n,
  output logic               dior_n,
  output logic               diow_n,
  output logic [DW-1:0]      dd,
  // Host sees
  input  wire logic          iordy,
  input  wire logic [DW-1:0] dd_bus
);
  // ----------------------------------------------------------------
  // Pin state
  // ----------------------------------------------------------------
  logic          drv;
  logic [DW-1:0] got[$];

  // Released bus keeps changing so a stale word never looks valid
  always @(posedge link_clk) begin
    if (!drv) begin
      dd <= ~dd;
    end
  end

  initial begin
    reset_n = 1'b0;
    dmack_n = 1'b1;
    dior_n  = 1'b1;
    diow_n  = 1'b1;
    dd      = 16'h0;
    drv     = 1'b0;
    repeat (20) @(posedge link_clk);
    reset_n <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Burst steps
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  task automatic grant();
    tick(1);
    diow_n  <= 1'b1;
    dmack_n <= 1'b0;
  endtask

  task automatic go();
    tick(1);
    diow_n <= 1'b0;
  endtask

  task automatic finish_burst();
    tick(1);
    diow_n <= 1'b1;
    tick(3);
    dmack_n <= 1'b1;
    dior_n  <= 1'b1;
    drv     <= 1'b0;
  endtask

  // Waits while the device negates DDMARDY-, then toggles HSTROBE
  task automatic send_word(input logic [DW-1:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge link_clk);
    while (iordy !== 1'b0 && n < 2000) begin
      @(negedge link_clk);
      n++;
    end
    ok = (n < 2000);
    // Bus claimed before the edge so the idle toggler keeps off it
    drv = 1'b1;
    @(posedge link_clk);
    dd  <= w;
    tick(2);
    dior_n <= ~dior_n;
    tick(4);
  endtask

  // Holds HDMARDY- low and takes a word on each DSTROBE change
  task automatic recv(input int cnt, output bit ok);
    logic last;
    int   n;
    ok = 1'b1;
    @(negedge link_clk);
    last = iordy;
    @(posedge link_clk);
    dior_n <= 1'b0;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      @(negedge link_clk);
      while (iordy === last && n < 2000) begin
        @(negedge link_clk);
        n++;
      end
      ok = ok && (n < 2000);
      last = iordy;
      got.push_back(dd_bus);
    end
    @(posedge link_clk);
    dior_n <= 1'b1;
  endtask
endmodule

/* File: testbench/tb_ata_udma_signal_role_mux.sv */
/*
  Self-checking bench of the line-role multiplexer.
  Assumes pull-ups on the open-drain lines and IORDY.
*/
`timescale 1ns/1ns
module tb_ata_udma_signal_role_mux
  import ata_role_pkg::*;
;
  // ----------------------------------------------------------------
  // Nets
  // ----------------------------------------------------------------
  logic          clk, link_clk, rst, ce, reset_n, dmack_n, dior_n, diow_n;
  logic [DW-1:0] host_dd, dd_o, rx_data, tx_data;
  logic          dd_oe, iordy_o, iordy_oe, dmarq_o, dmarq_oe;
  logic          intrq_o, intrq_oe, pdiag_n_o, pdiag_n_oe;
  logic          dasp_n_o, dasp_n_oe, udma_mode, xfer_read, dma_req;
  logic          intr_req, intr_en, pdiag_assert, dasp_assert, pio_wait;
  logic          rx_valid, rx_ready, tx_valid, tx_ready;
  logic          burst_active, stop_seen, pdiag_low, dasp_low;
  logic [DW-1:0] rx_q[$];
  int            err_total, check_count;
  wire [DW-1:0]  dd_bus  = dd_oe ? dd_o : host_dd;
  wire           iordy_w = iordy_oe ? iordy_o : 1'b1;
  wire           pdiag_w = pdiag_n_oe ? pdiag_n_o : 1'b1;
  wire           dasp_w  = dasp_n_oe ? dasp_n_o : 1'b1;

  always #50 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    // Offset keeps link edges off every system clock edge
    #1;
    forever begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
    end
  end

  ata_udma_role_mux uut (
    .clk, .ce, .rst, .link_clk, .reset_n_i(reset_n),
    .dmack_n_i(dmack_n), .dior_n_i(dior_n), .diow_n_i(diow_n),
    .dd_i(dd_bus), .pdiag_n_i(pdiag_w), .dasp_n_i(dasp_w),
    .dd_o, .dd_oe, .iordy_o, .iordy_oe, .dmarq_o, .dmarq_oe,
    .intrq_o, .intrq_oe, .pdiag_n_o, .pdiag_n_oe, .dasp_n_o,
    .dasp_n_oe, .udma_mode, .xfer_read, .dma_req, .intr_req, .intr_en,
    .pdiag_assert, .dasp_assert, .pio_wait, .rx_data, .rx_valid,
    .rx_ready, .tx_data, .tx_valid, .tx_ready, .burst_active,
    .stop_seen, .pdiag_low, .dasp_low
  );

  host_model host (
    .link_clk, .reset_n, .dmack_n, .dior_n, .diow_n, .dd(host_dd),
    .iordy(iordy_w), .dd_bus
  );

  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      rx_q.push_back(rx_data);
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk1(input logic got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chkw(input logic [DW-1:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic [DW-1:0] wv(input int i);
    return {8'ha5, 8'(i * 37)};
  endfunction

  task automatic send_tx(input logic [DW-1:0] w);
    int n;
    n = 0;
    @(negedge clk);
    tx_data  = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk1(n < 500, 1'b1, "tx accept");
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pio(input logic pw, dr, ir, ie, pa, da);
    @(negedge clk);
    {pio_wait, dma_req, intr_req, intr_en} = {pw, dr, ir, ie};
    {pdiag_assert, dasp_assert} = {pa, da};
    cyc(20);
    chk1(iordy_oe, pw, "pio iordy enable");
    chk1(iordy_o, WAIT_LVL, "pio iordy level");
    chk1(dmarq_o & dmarq_oe, dr, "dmarq");
    chk1(intrq_o, ir, "intrq level");
    chk1(intrq_oe, ie, "intrq enable");
    chk1(dd_oe, 1'b0, "pio bus idle");
    chk1(pdiag_n_oe, pa, "pdiag pull");
    chk1(dasp_n_oe, da, "dasp pull");
    chk1(pdiag_low, pa, "pdiag sample");
    chk1(dasp_low, da, "dasp sample");
  endtask

  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    cyc(5);
    intr_req = 1'b1;
    cyc(20);
    chk1(intrq_o, 1'b0, "held while disabled");
    ce = 1'b1;
    cyc(20);
    chk1(intrq_o, 1'b1, "intrq after enable");
    intr_req = 1'b0;
  endtask

  task automatic t_nomode();
    @(negedge clk);
    udma_mode = 1'b0;
    xfer_read = 1'b1;
    host.grant();
    cyc(20);
    chk1(dd_oe | iordy_oe | burst_active, 1'b0, "no mode roles");
    chk1(dmarq_oe, 1'b1, "dmarq held in grant");
    host.finish_burst();
    cyc(20);
    chk1(dmarq_oe, 1'b0, "dmarq released");
  endtask

  task automatic t_write();
    bit ok;
    int n;
    @(negedge clk);
    {udma_mode, xfer_read, rx_ready} = 3'b100;
    host.grant();
    cyc(20);
    chk1(iordy_oe & burst_active, 1'b1, "write role");
    chk1(iordy_o, 1'b0, "ddmardy asserted");
    chk1(dd_oe, 1'b0, "write bus direction");
    chk1(stop_seen, 1'b1, "stop at grant");
    host.go();
    fork
      for (int i = 0; i < 8; i++) begin
        host.send_word(wv(i), ok);
        chk1(ok, 1'b1, "host stalled");
      end
      begin
        cyc(40);
        chk1(iordy_o, 1'b1, "ddmardy pause when full");
        chkw(rx_data, wv(0), "held word");
        rx_ready = 1'b1;
      end
    join
    n = 0;
    while (rx_q.size() < 8 && n < 500) begin
      cyc(1);
      n++;
    end
    chk1(rx_q.size() == 8, 1'b1, "word count");
    for (int i = 0; i < rx_q.size(); i++) begin
      chkw(rx_q[i], wv(i), "write word");
    end
    chk1(stop_seen, 1'b0, "stop negated");
    host.finish_burst();
    cyc(20);
    chk1(iordy_oe | burst_active, 1'b0, "back to pio");
  endtask

  task automatic t_read();
    bit ok;
    @(negedge clk);
    {udma_mode, xfer_read} = 2'b11;
    host.grant();
    cyc(20);
    chk1(dd_oe & iordy_oe, 1'b1, "read role");
    host.go();
    send_tx(wv(20));
    cyc(30);
    chk1(iordy_o, 1'b0, "no dstrobe while paused");
    fork
      host.recv(3, ok);
      begin
        send_tx(wv(21));
        send_tx(wv(22));
      end
    join
    chk1(ok, 1'b1, "dstrobe missing");
    for (int i = 0; i < host.got.size(); i++) begin
      chkw(host.got[i], wv(20 + i), "read word");
    end
    host.finish_burst();
    cyc(20);
    chk1(dd_oe | iordy_oe, 1'b0, "read roles dropped");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {clk, rst, ce, udma_mode, xfer_read, dma_req} = 6'b011000;
    {intr_req, intr_en, pdiag_assert, dasp_assert, pio_wait} = 5'b00000;
    {rx_ready, tx_valid, tx_data} = {2'b10, 16'h0};
    err_total   = 0;
    check_count = 0;
    cyc(5);
    chk1(dd_oe | iordy_oe | dmarq_oe | intrq_oe, 1'b0, "reset");
    @(negedge clk);
    rst = 1'b0;
    cyc(4);
    t_pio(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    t_pio(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    t_pio(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    t_freeze();
    t_nomode();
    t_write();
    t_read();
    wrap_up();
  end

  // The whole run needs well under a millisecond
  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule
